// file: core/sir_bit_tick.sv
// Purpose: half-period tick for the serial clock
// Assumes: div_i of zero is raised to the least legal divider
// Notes:   one tick every div+1 clocks, so the bus clock is clk/(div+1)/2
`timescale 1ns/1ps
module sir_bit_tick
   import sir_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             run_i,
   input  wire logic [DIV_W-1:0] div_i,
   output logic                  tick_o
);
   logic [DIV_W-1:0] cnt_ff;
   logic [DIV_W-1:0] nxt_cnt;
   logic [DIV_W-1:0] lim;

   always_comb begin
      lim     = (div_i < DIV_MIN) ? DIV_MIN : div_i;
      tick_o  = run_i && (cnt_ff >= lim);
      nxt_cnt = (!run_i || tick_o) ? '0 : DIV_W'(cnt_ff + 1'b1);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule

// file: core/sir_event_flag.sv
// Purpose: sticky event flag, cleared by writing a one
// Assumes: set and clear are one-cycle strobes
// Notes:   set wins over a clear in the same cycle so no event is lost
`timescale 1ns/1ps
module sir_event_flag (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   logic flag_ff;
   logic nxt_flag;

   always_comb begin
      nxt_flag = set_i ? 1'b1 : (clr_i ? 1'b0 : flag_ff);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag_o = flag_ff;
endmodule

// file: core/sir_pkg.sv
// Purpose: shared constants and types of the two-wire master receive channel
// Assumes: 32-bit classic Wishbone, registers 16 bits wide in the low lanes
// Notes:   one name for every offset, field and reset value
package sir_pkg;
   localparam int unsigned AW = 8;
   localparam int unsigned DW = 32;
   localparam int unsigned RW = 16;
   // -----------------------------------------------------------------
   // register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [AW-1:0] OFS_MODE   = 8'h00;
   localparam logic [AW-1:0] OFS_OPCFG  = 8'h04;
   localparam logic [AW-1:0] OFS_DATA   = 8'h08;
   localparam logic [AW-1:0] OFS_OUTLVL = 8'h0C;
   localparam logic [AW-1:0] OFS_OUTEN  = 8'h10;
   localparam logic [AW-1:0] OFS_START  = 8'h14;
   localparam logic [AW-1:0] OFS_STOP   = 8'h18;
   localparam logic [AW-1:0] OFS_STATUS = 8'h1C;
   localparam logic [AW-1:0] OFS_MASK   = 8'h20;
   // -----------------------------------------------------------------
   // fields
   // -----------------------------------------------------------------
   localparam int unsigned   MD_MSB     = 2;
   localparam logic [2:0]    MD_IIC     = 3'h4;
   localparam int unsigned   MODE_FIX   = 5;
   localparam int unsigned   OPC_TXE    = 15;
   localparam int unsigned   OPC_RXE    = 14;
   localparam int unsigned   DIV_LSB    = 9;
   localparam int unsigned   DIV_W      = 7;
   localparam logic [6:0]    DIV_MIN    = 7'h01;
   localparam int unsigned   BYTE_W     = 8;
   localparam logic [3:0]    ACK_SLOT   = 4'h8;
   localparam int unsigned   LVL_CKO    = 8;
   localparam int unsigned   LVL_SO     = 0;
   localparam int unsigned   CTL_BIT    = 0;
   localparam int unsigned   ST_BUSY    = 1;
   localparam int unsigned   EV_END     = 0;
   localparam int unsigned   EV_OVR     = 1;
   localparam int unsigned   NUM_EV     = 2;
   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [RW-1:0] RST_MODE   = 16'h0000;
   localparam logic [RW-1:0] RST_OPCFG  = 16'h0000;
   localparam logic [RW-1:0] RST_OUTLVL = 16'h0101;
   localparam logic [DW-1:0] RD_ZERO    = 32'h0000_0000;
   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [AW-1:0] adr;
      logic [DW-1:0] dat;
      logic [3:0]    sel;
      logic          we;
      logic          cyc;
      logic          stb;
   } sir_wb_req_s;
   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } sir_pins_s;
   typedef enum logic [2:0] {
      ST_IDLE, ST_LOW, ST_HIGH, ST_SP_LOW, ST_SP_HIGH, ST_SP_REL
   } sir_state_e;
endpackage

// file: core/sir_rx_channel.sv
// Purpose: receive channel of a simplified two-wire master, Wishbone slave
// Assumes: address field already sent by the transmit path (addr_sent_i)
// Notes:   open-drain pins: output low, enable high while pulling low
//
// Functional notes
// - bytes are received only after the address field was sent
// - after the last byte the master makes a stop and frees the bus
// - only a transfer-end interrupt per byte, no buffer-empty interrupt; the overrun flag also raises irq_o when unmasked
// - overrun is the only error flag during reception
// - bus clock at most a quarter of clock; divider at least one
// - data not inverted, output level high while idle
// - one extra bit slot per byte in which the master acknowledges
// - received byte in low 8 data bits, divider above it
// - clock and data level bits follow the bus while running
// - no acknowledge driven for the last byte
`timescale 1ns/1ps
module sir_rx_channel
   import sir_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire sir_pkg::sir_wb_req_s wb_req_i,
   output logic [sir_pkg::DW-1:0]    wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 addr_sent_i,
   input  wire logic                 scl_i,
   input  wire logic                 sda_i,
   output sir_pkg::sir_pins_s        pins_o,
   output logic                      irq_o
);
   import sir_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   sir_state_e        state_ff,  nxt_state;
   logic [RW-1:0]     mode_ff,   nxt_mode;
   logic [RW-1:0]     opcfg_ff,  nxt_opcfg;
   logic [RW-1:0]     outlvl_ff, nxt_outlvl;
   logic [DIV_W-1:0]  div_ff,    nxt_div;
   logic [BYTE_W-1:0] shift_ff,  nxt_shift;
   logic [BYTE_W-1:0] rxbyte_ff, nxt_rxbyte;
   logic [3:0]        bit_ff,    nxt_bit;
   logic              outen_ff,  nxt_outen;
   logic              run_ff,    nxt_run;
   logic              stop_ff,   nxt_stop;
   logic              unread_ff, nxt_unread;
   logic              scl_ff,    nxt_scl;
   logic              sda_ff,    nxt_sda;
   logic              ack_ff,    nxt_ack;
   logic [DW-1:0]     rdat_ff,   nxt_rdat;
   logic [NUM_EV-1:0] mask_ff,   nxt_mask;

   logic              tick;
   logic              acc;
   logic              wr;
   logic [RW-1:0]     wmask;
   logic [RW-1:0]     wdat;
   logic              busy;
   logic              ready;
   logic              ev_end;
   logic              ev_ovr;
   logic [NUM_EV-1:0] ev_clr;
   logic [NUM_EV-1:0] status;
   logic              cur_scl;
   logic              cur_sda;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   sir_bit_tick u_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (busy),
      .div_i  (div_ff),
      .tick_o (tick)
   );

   sir_event_flag u_end (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (ev_end),
      .clr_i  (ev_clr[EV_END]),
      .flag_o (status[EV_END])
   );

   sir_event_flag u_ovr (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (ev_ovr),
      .clr_i  (ev_clr[EV_OVR]),
      .flag_o (status[EV_OVR])
   );

   assign busy  = (state_ff != ST_IDLE);
   assign acc   = wb_req_i.cyc && wb_req_i.stb && !ack_ff;
   assign wr    = acc && wb_req_i.we;
   assign wmask = {{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
   assign wdat  = wb_req_i.dat[RW-1:0] & wmask;
   // byte start needs a running channel set up for reception
   assign ready = run_ff && addr_sent_i && !stop_ff
                  && (mode_ff[MD_MSB:0] == MD_IIC) && mode_ff[MODE_FIX]
                  && opcfg_ff[OPC_RXE] && !opcfg_ff[OPC_TXE];
   // pins follow the engine while a channel runs or the engine is busy (stop included), else software levels
   assign cur_scl = (run_ff || busy) ? scl_ff : outlvl_ff[LVL_CKO];
   assign cur_sda = (run_ff || busy) ? sda_ff : outlvl_ff[LVL_SO];

   // -----------------------------------------------------------------
   // engine and registers
   // -----------------------------------------------------------------
   always_comb begin
      nxt_state  = state_ff;
      nxt_mode   = mode_ff;
      nxt_opcfg  = opcfg_ff;
      nxt_outlvl = outlvl_ff;
      nxt_div    = div_ff;
      nxt_shift  = shift_ff;
      nxt_rxbyte = rxbyte_ff;
      nxt_bit    = bit_ff;
      nxt_outen  = outen_ff;
      nxt_run    = run_ff;
      nxt_stop   = stop_ff;
      nxt_unread = unread_ff;
      nxt_scl    = scl_ff;
      nxt_sda    = sda_ff;
      nxt_mask   = mask_ff;
      nxt_ack    = acc;
      nxt_rdat   = rdat_ff;
      ev_end     = 1'b0;
      ev_ovr     = 1'b0;
      ev_clr     = '0;

      // bus writes
      if (wr) begin
         case (wb_req_i.adr)
            OFS_MODE: begin
               if (!busy) begin
                  nxt_mode = (mode_ff & ~wmask) | wdat;
               end
            end
            OFS_OPCFG: begin
               if (!busy) begin
                  nxt_opcfg = (opcfg_ff & ~wmask) | wdat;
               end else begin
                  // only the two enables may move mid-transfer
                  nxt_opcfg[OPC_TXE] = wmask[OPC_TXE] ? wdat[OPC_TXE] : opcfg_ff[OPC_TXE];
                  nxt_opcfg[OPC_RXE] = wmask[OPC_RXE] ? wdat[OPC_RXE] : opcfg_ff[OPC_RXE];
               end
            end
            OFS_DATA: begin
               if (wmask[RW-1]) begin
                  nxt_div = wdat[RW-1:DIV_LSB];
               end
               // a data write launches one byte of reception
               if (!busy && ready && wmask[0]) begin
                  nxt_state = ST_LOW;
                  nxt_bit   = '0;
                  nxt_scl   = 1'b0;
                  nxt_sda   = 1'b1;
               end
            end
            OFS_OUTLVL: begin
               if (!busy && !run_ff) begin
                  nxt_outlvl = (outlvl_ff & ~wmask) | wdat;
               end
            end
            OFS_OUTEN: begin
               if (wmask[CTL_BIT] && !busy) begin
                  nxt_outen = wdat[CTL_BIT];
               end
            end
            OFS_START: begin
               if (wdat[CTL_BIT] && !busy && !run_ff) begin
                  nxt_run = 1'b1;
                  nxt_scl = outlvl_ff[LVL_CKO];
                  nxt_sda = outlvl_ff[LVL_SO];
               end
            end
            OFS_STOP: begin
               if (wdat[CTL_BIT] && run_ff) begin
                  nxt_run  = 1'b0;
                  nxt_stop = 1'b1;
               end
            end
            OFS_STATUS: begin
               ev_clr = wdat[NUM_EV-1:0];
            end
            OFS_MASK: begin
               nxt_mask = (mask_ff & ~wmask[NUM_EV-1:0]) | wdat[NUM_EV-1:0];
            end
            default: begin
            end
         endcase
      end

      // bus reads, answered in the ack cycle
      if (acc && !wb_req_i.we) begin
         case (wb_req_i.adr)
            OFS_MODE:   nxt_rdat = {16'h0000, mode_ff};
            OFS_OPCFG:  nxt_rdat = {16'h0000, opcfg_ff};
            OFS_DATA:   nxt_rdat = {16'h0000, div_ff, 1'b0, rxbyte_ff};
            OFS_OUTLVL: begin
               nxt_rdat = {16'h0000, outlvl_ff};
               nxt_rdat[LVL_CKO] = cur_scl;
               nxt_rdat[LVL_SO]  = cur_sda;
            end
            OFS_OUTEN:  nxt_rdat = {31'h0000_0000, outen_ff};
            OFS_START:  nxt_rdat = {30'h0000_0000, busy, run_ff};
            OFS_STATUS: nxt_rdat = {30'h0000_0000, status};
            OFS_MASK:   nxt_rdat = {30'h0000_0000, mask_ff};
            default:    nxt_rdat = RD_ZERO;
         endcase
         if (wb_req_i.adr == OFS_DATA) begin
            nxt_unread = 1'b0;
         end
      end

      // bit engine
      case (state_ff)
         ST_IDLE: begin
            if (stop_ff) begin
               nxt_state = ST_SP_LOW;
               nxt_scl   = 1'b0;
               nxt_sda   = 1'b0;
            end
         end
         ST_LOW: begin
            if (tick) begin
               nxt_scl   = 1'b1;
               nxt_state = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (tick) begin
               nxt_scl = 1'b0;
               if (bit_ff == ACK_SLOT) begin
                  nxt_sda    = 1'b1;
                  nxt_state  = ST_IDLE;
                  nxt_rxbyte = shift_ff;
                  nxt_unread = 1'b1;
                  ev_end     = 1'b1;
                  ev_ovr     = unread_ff;
               end else begin
                  nxt_shift = {shift_ff[BYTE_W-2:0], sda_i};
                  nxt_bit   = 4'(bit_ff + 1'b1);
                  nxt_state = ST_LOW;
                  // extra slot: pull low to acknowledge, release for last byte
                  if (4'(bit_ff + 1'b1) == ACK_SLOT) begin
                     nxt_sda = !outen_ff;
                  end
               end
            end
         end
         ST_SP_LOW: begin
            if (tick) begin
               nxt_scl   = 1'b1;
               nxt_state = ST_SP_HIGH;
            end
         end
         ST_SP_HIGH: begin
            if (tick) begin
               nxt_sda   = 1'b1;
               nxt_state = ST_SP_REL;
            end
         end
         ST_SP_REL: begin
            if (tick) begin
               nxt_state           = ST_IDLE;
               nxt_stop            = 1'b0;
               nxt_outlvl[LVL_CKO] = 1'b1;
               nxt_outlvl[LVL_SO]  = 1'b1;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff  <= ST_IDLE;
         mode_ff   <= RST_MODE;
         opcfg_ff  <= RST_OPCFG;
         outlvl_ff <= RST_OUTLVL;
         div_ff    <= DIV_MIN;
         shift_ff  <= '0;
         rxbyte_ff <= '0;
         bit_ff    <= '0;
         outen_ff  <= 1'b0;
         run_ff    <= 1'b0;
         stop_ff   <= 1'b0;
         unread_ff <= 1'b0;
         scl_ff    <= 1'b1;
         sda_ff    <= 1'b1;
         mask_ff   <= '0;
         ack_ff    <= 1'b0;
         rdat_ff   <= RD_ZERO;
      end else begin
         state_ff  <= nxt_state;
         mode_ff   <= nxt_mode;
         opcfg_ff  <= nxt_opcfg;
         outlvl_ff <= nxt_outlvl;
         div_ff    <= nxt_div;
         shift_ff  <= nxt_shift;
         rxbyte_ff <= nxt_rxbyte;
         bit_ff    <= nxt_bit;
         outen_ff  <= nxt_outen;
         run_ff    <= nxt_run;
         stop_ff   <= nxt_stop;
         unread_ff <= nxt_unread;
         scl_ff    <= nxt_scl;
         sda_ff    <= nxt_sda;
         mask_ff   <= nxt_mask;
         ack_ff    <= nxt_ack;
         rdat_ff   <= nxt_rdat;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // scl_i is not watched: no clock stretching by the slave is honoured
   assign pins_o.scl_o  = 1'b0;
   assign pins_o.scl_oe = !cur_scl;
   assign pins_o.sda_o  = 1'b0;
   assign pins_o.sda_oe = !cur_sda;
   assign wb_ack_o      = ack_ff;
   assign wb_dat_o      = rdat_ff;
   assign irq_o         = |(status & mask_ff);
endmodule

// file: test/sir_rx_channel_properties.sv
// Purpose: port checks of the receive channel
// Assumes: one clock domain, synchronous reset
// Notes:   bound to every channel instance
`timescale 1ns/1ps
module sir_rx_channel_properties
   import sir_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire sir_pkg::sir_wb_req_s   wb_req_i,
   input  wire logic [sir_pkg::DW-1:0] wb_dat_o,
   input  wire logic                   wb_ack_o,
   input  wire logic                   addr_sent_i,
   input  wire logic                   scl_i,
   input  wire logic                   sda_i,
   input  wire sir_pkg::sir_pins_s     pins_o,
   input  wire logic                   irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ------------------------------------
   // bus and line relations
   // ------------------------------------
   sequence s_take;
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_pulse: assert property (s_take |=> s_pulse)
      else $error("ack is not a single pulse after a request");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read lanes not zero");
   a_data_gap: assert property (s_take ##0 (!wb_req_i.we && wb_req_i.adr == OFS_DATA)
      |=> !wb_dat_o[8])
      else $error("gap bit between divider and byte not zero");
   a_rst_idle: assert property ($fell(rst_i)
      |-> !pins_o.scl_oe && !pins_o.sda_oe && !irq_o && !wb_ack_o)
      else $error("lines or irq not idle after reset");
   a_open_drain: assert property (!pins_o.scl_o && !pins_o.sda_o)
      else $error("pin output level not low");
   a_scl_high_min: assert property ($fell(pins_o.scl_oe) |=> !pins_o.scl_oe)
      else $error("clock high shorter than two cycles");
   a_scl_low_min: assert property ($rose(pins_o.scl_oe) |=> pins_o.scl_oe)
      else $error("clock low shorter than two cycles");
   a_sda_take_low: assert property ($rose(pins_o.sda_oe) |-> pins_o.scl_oe)
      else $error("data pulled low while clock high");
   a_sda_stop_only: assert property ($changed(pins_o.sda_oe) && !pins_o.scl_oe
      |-> !pins_o.sda_oe)
      else $error("data change under high clock is not a release");
   a_irq_cause: assert property ($rose(irq_o)
      |-> pins_o.scl_oe || $past(wb_req_i.cyc && wb_req_i.we))
      else $error("irq rose outside byte end or register write");
endmodule

bind sir_rx_channel sir_rx_channel_properties i_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .addr_sent_i(addr_sent_i), .scl_i(scl_i), .sda_i(sda_i),
   .pins_o(pins_o), .irq_o(irq_o)
);

// file: test/sir_rx_channel_tb.sv
// Purpose: self-checking bench of the receive channel
// Assumes: pull-ups on both lines, slave model on the far side
// Notes:   expected bytes kept in a queue
`timescale 1ns/1ps
module sir_rx_channel_tb;
   import sir_pkg::*;
   localparam logic [AW-1:0] ROFS[7] = '{OFS_MODE, OFS_OPCFG, OFS_DATA, OFS_OUTLVL,
                                         OFS_OUTEN, OFS_STATUS, 8'h3C};
   localparam logic [15:0]   RVAL[7] = '{16'h0000, 16'h0000, 16'h0200, 16'h0101,
                                         16'h0000, 16'h0000, 16'h0000};
   logic          clk_i       = 1'b0;
   logic          rst_i       = 1'b1;
   logic          addr_sent_i = 1'b0;
   sir_wb_req_s   wb_req_i    = '0;
   logic [DW-1:0] wb_dat_o;
   logic          wb_ack_o;
   logic          irq_o;
   sir_pins_s     pins_o;
   logic          sl_en       = 1'b0;
   logic [7:0]    sl_byte     = 8'h00;
   logic          sl_oe;
   logic          sl_ack;
   int            sl_stops;
   int            hi_cnt      = 0;
   int            error_cnt   = 0;
   int            cmp_count   = 0;
   int            seed        = 32'hFE17;
   int            rx_q[$];
   logic [DW-1:0] rd;
   int            h;
   wire           scl_w       = !pins_o.scl_oe;
   wire           sda_w       = !(pins_o.sda_oe || sl_oe);

   always #2.5 clk_i = !clk_i;
   always @(posedge clk_i) if (scl_w) hi_cnt <= hi_cnt + 1;

   sir_rx_channel i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .addr_sent_i(addr_sent_i), .scl_i(scl_w), .sda_i(sda_w),
      .pins_o(pins_o), .irq_o(irq_o));
   sir_slave_model i_slave (
      .clk_i(clk_i), .en_i(sl_en), .byte_i(sl_byte), .scl_i(scl_w), .sda_i(sda_w),
      .sda_oe_o(sl_oe), .ack_o(sl_ack), .stops_o(sl_stops));
   // ------------------------------------
   // checking and bus tasks
   // ------------------------------------
   task automatic chk(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic tmo();
      error_cnt++;
      $display("[ERR] wait expected done seen timeout");
      conclude();
   endtask
   // request held until ack is sampled, then one idle cycle
   task automatic wb(input logic [AW-1:0] a, input logic we, input logic [3:0] s,
                     input logic [DW-1:0] d);
      int i;
      i = 0;
      wb_req_i <= '{adr: a, dat: d, sel: s, we: we, cyc: 1'b1, stb: 1'b1};
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 20);
      if (wb_ack_o !== 1'b1) tmo();
      rd = wb_dat_o;
      wb_req_i <= '0;
      @(posedge clk_i);
   endtask
   // divider goes in with the write that starts the byte
   task automatic rx_byte(input logic [6:0] div, input bit do_rd, input logic ackv);
      logic [7:0] b;
      int         h0;
      int         i;
      b = 8'($random(seed));
      sl_byte <= b;
      h0 = hi_cnt;
      wb(OFS_DATA, 1'b1, 4'h3, {16'h0000, div, 9'h000});
      // no register write while the byte runs
      for (i = 0; i < 400 && irq_o !== 1'b1; i++)
         @(posedge clk_i);
      if (irq_o !== 1'b1) tmo();
      if (rx_q.size() > 0) rx_q.delete();
      rx_q.push_back(b);
      chk("clock high cycles", hi_cnt - h0, 9 * ((div == 0 ? 1 : div) + 1));
      chk("ack slot level", sl_ack, ackv);
      wb(OFS_STATUS, 1'b1, 4'h1, 32'h0000_0001);
      chk("irq after clear", irq_o, 1'b0);
      if (do_rd) begin
         wb(OFS_DATA, 1'b0, 4'hF, 32'h0000_0000);
         chk("received byte", rd, {16'h0000, div, 1'b0, 8'(rx_q.pop_front())});
      end
   endtask
   // ------------------------------------
   // main sequence
   // ------------------------------------
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int k = 0; k < 7; k++) begin
         wb(ROFS[k], 1'b0, 4'hF, 32'h0000_0000);
         chk("reset value", rd, {16'h0000, RVAL[k]});
      end
      $display("test reset values done");
      wb(OFS_MODE, 1'b1, 4'h3, 32'h0000_0024);
      wb(OFS_OPCFG, 1'b1, 4'h3, 32'h0000_4017);
      wb(OFS_OUTLVL, 1'b1, 4'h3, 32'h0000_0001);
      // outen set so bytes are acknowledged, end interrupt unmasked, then the channel started
      wb(OFS_OUTEN, 1'b1, 4'h1, 32'h0000_0001);
      wb(OFS_MASK, 1'b1, 4'h1, 32'h0000_0001);
      wb(OFS_START, 1'b1, 4'h1, 32'h0000_0001);
      wb(OFS_MODE, 1'b0, 4'hF, 32'h0000_0000);
      chk("mode readback", rd, 32'h0000_0024);
      wb(OFS_START, 1'b0, 4'hF, 32'h0000_0000);
      chk("running not busy", rd, 32'h0000_0001);
      sl_en <= 1'b1;
      h = hi_cnt;
      wb(OFS_DATA, 1'b1, 4'h3, 32'h0000_0400);
      repeat (60) @(posedge clk_i);
      chk("clock without address", hi_cnt - h, 0);
      chk("irq without address", irq_o, 1'b0);
      $display("test address gate done");
      addr_sent_i <= 1'b1;
      // small dividers keep runs short; clk_i stands for a slow operation clock
      for (int k = 0; k < 4; k++)
         rx_byte(7'(1 + ($unsigned($random(seed)) % 3)), 1'b1, 1'b0);
      $display("test byte stream done");
      rx_byte(7'h00, 1'b0, 1'b0);
      rx_byte(7'h02, 1'b1, 1'b0);
      wb(OFS_STATUS, 1'b0, 4'hF, 32'h0000_0000);
      chk("overrun status", rd, 32'h0000_0002);
      wb(OFS_MASK, 1'b1, 4'h1, 32'h0000_0003);
      chk("irq on overrun", irq_o, 1'b1);
      wb(OFS_STATUS, 1'b1, 4'h1, 32'h0000_0002);
      chk("irq after overrun clear", irq_o, 1'b0);
      $display("test overrun done");
      wb(OFS_OUTEN, 1'b1, 4'h1, 32'h0000_0000);
      rx_byte(7'h02, 1'b1, 1'b1);
      $display("test last byte done");
      sl_en <= 1'b0;
      wb(OFS_STOP, 1'b1, 4'h1, 32'h0000_0001);
      for (int k = 0; k < 200 && sl_stops < 1; k++)
         @(posedge clk_i);
      chk("stop conditions", sl_stops, 1);
      repeat (8) @(posedge clk_i);
      chk("lines after stop", {scl_w, sda_w}, 2'b11);
      wb(OFS_OUTLVL, 1'b0, 4'hF, 32'h0000_0000);
      chk("levels after stop", rd, 32'h0000_0101);
      $display("test stop done");
      conclude();
   end
endmodule

// file: test/sir_slave_model.sv
// Purpose: addressed slave sending bytes to the channel
// Assumes: lines resolved with pull-ups by the bench
// Notes:   slot counter cleared while disabled
`timescale 1ns/1ps
module sir_slave_model (
   input  wire logic       clk_i,
   input  wire logic       en_i,
   input  wire logic [7:0] byte_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_oe_o,
   output logic            ack_o,
   output int              stops_o
);
   logic [3:0] slot;
   logic       scl_q;
   logic       sda_q;
   initial begin
      slot = 4'h0;
      scl_q = 1'b1;
      sda_q = 1'b1;
      ack_o = 1'b1;
      stops_o = 0;
   end
   always @(posedge clk_i) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (!en_i)
         slot <= 4'h0;
      else if (scl_q && !scl_i)
         slot <= (slot == 4'h8) ? 4'h0 : slot + 4'h1;
      if (en_i && scl_i && !scl_q && slot == 4'h8)
         ack_o <= sda_i;
      if (scl_i && scl_q && sda_i && !sda_q)
         stops_o <= stops_o + 1;
   end
   // data changes only under low clock; released in the ack slot
   assign sda_oe_o = en_i && slot < 4'h8 && !byte_i[3'h7 - slot[2:0]];
endmodule
